// >>> logic/atapi_host_irq_status.v
// interface status, host control views and interrupt outputs of the atapi port
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "atapi_irq_map.vh"
// Contract
// - host soft reset bit sets busy status; in atapi mode it also sets the soft-reset flag.
// - nien low and drive selected: host interrupt pin actively driven.
// - nien high or not selected: host interrupt pin released.
// - device control view reads bit3 as 1, bit0 as 0, bits 7..4 zero.
// - features view shows overlap in bit 1, dma in bit 0.
// - writing 1 to a status interrupt bit clears it and its interrupt.
// - status bits 3, 1 and 0 never raise the cpu interrupt.
// - atapi mode: host command write while selected sets command flag.
// - atapi mode: diagnostic command code sets command flag regardless of selection.
// - command flag clears on command register read or write of 1.
// - transfer end sets its flag; ack write or write of 1 clears it.
// - atapi mode: packet received or memory transfer also sets end; maskable.
// - when enabled, each packet size reload in autodrq sets request flag.
// - when enabled, early host stop of ultra dma sets stop flag.
// - trigger write sets transfer busy; transfer end clears it.
// - soft-reset flag clears on device control read or write of 1.
// - soft-reset flag in atapi mode always asserts cpu interrupt.
// - last command was reset code sets flag; command read clears it.
// - packet sequence done sets flag; ack register write clears it.
// - after ultra dma, same bit low means last transfer corrupt.
// - selected only while host drive bit equals configured device number.
module atapi_host_irq_status (
  input  wire        i_clk,
  input  wire        i_resetn,
  input  wire [15:0] i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [7:0]  i_writedata,
  output reg  [7:0]  o_readdata,
  output wire        o_waitrequest,
  input  wire        i_host_devctl_we,
  input  wire [7:0]  i_host_devctl_data,
  input  wire        i_host_feat_we,
  input  wire [7:0]  i_host_feat_data,
  input  wire        i_host_cmd_we,
  input  wire [7:0]  i_host_cmd_data,
  input  wire        i_host_drive_bit,
  input  wire        i_xfer_end,
  input  wire        i_packet_rcvd,
  input  wire        i_mem_xfer_done,
  input  wire        i_pkt_reload,
  input  wire        i_ultra_early_stop,
  input  wire        i_ultra_remaining_nz,
  input  wire        i_pkt_seq_done,
  input  wire        i_ultra_xfer_end,
  input  wire        i_ultra_crc_ok,
  input  wire        i_host_irq_req,
  output wire        o_host_irq_out,
  output wire        o_host_irq_oe,
  output reg         o_host_busy_set,
  output wire        o_cpu_irq
);
  reg  [7:0] devctl_r;
  reg  [7:0] feat_r;
  reg  [7:0] cmd_r;
  reg  [7:0] cfg_r;
  reg  [7:0] stat_r;
  wire [7:0] stat_nxt;
  reg  [7:0] rd_mux;
  reg        ack_r;
  wire       req;
  wire       take;
  wire       selected;
  wire       wr_status;
  wire       rd_cmd;
  wire       rd_devctl;
  wire       wr_ack;
  wire       wr_trig;
  wire       wr_cfg;
  wire       atapi;
  wire       srst_rise;
  wire       cmd_accept;
  wire       cmd_is_diag;
  wire       cmd_is_reset;
  wire       xend_event;
  wire       drq_event;
  wire       ustop_event;
  wire       pkt_event;
  wire [7:0] w1c;
  wire [7:0] set_req;
  wire [7:0] set_val;
  wire [7:0] clr_req;
  wire [7:0] irq_en;
  wire [7:0] devctl_view;
  wire [7:0] feat_view;

  // one-cycle answer: wait on the first cycle of a request, release on the next
  assign req           = i_read | i_write;
  assign o_waitrequest = req & ~ack_r;
  assign take          = req & ack_r;
  assign wr_cfg        = take & i_write & (i_address == `OFS_DEVCFG);

  assign atapi     = cfg_r[`CFG_ATAPI];
  assign selected  = (i_host_drive_bit == cfg_r[`CFG_DEVNUM]);
  assign wr_status = take & i_write & (i_address == `OFS_IRQ_STATUS);
  assign rd_cmd    = take & i_read & (i_address == `OFS_CMD_READ);
  assign rd_devctl = take & i_read & (i_address == `OFS_DEVCTL_VIEW);
  assign wr_ack    = take & i_write & (i_address == `OFS_XFER_ACK);
  assign wr_trig   = take & i_write & (i_address == `OFS_XFER_TRIG);
  assign srst_rise = i_host_devctl_we & i_host_devctl_data[2] & ~devctl_r[2];
  // only interrupt bits honour write-one clear
  assign w1c = wr_status ? (i_writedata & 8'hf4) : 8'h00;

  // host interrupt pin: driven only when enabled and selected
  assign o_host_irq_oe  = ~devctl_r[1] & selected;
  assign o_host_irq_out = i_host_irq_req & o_host_irq_oe;

  // flags 3,1,0 are excluded from the cpu interrupt
  assign irq_en[`BIT_CMD_IRQ]   = 1'b1;
  assign irq_en[`BIT_XEND_IRQ]  = ~cfg_r[`CFG_XEND_MASK];
  assign irq_en[`BIT_DRQ_IRQ]   = 1'b1;
  assign irq_en[`BIT_USTOP_IRQ] = 1'b1;
  assign irq_en[`BIT_XBUSY]     = 1'b0;
  assign irq_en[`BIT_SRST_IRQ]  = atapi;
  assign irq_en[`BIT_RST_CMD]   = 1'b0;
  assign irq_en[`BIT_PKT_DONE]  = 1'b0;
  assign o_cpu_irq = |(stat_r & irq_en);

  // command decode shared by the command flag, reset flag and command latch
  assign cmd_is_diag  = (i_host_cmd_data == `CODE_DIAG);
  assign cmd_is_reset = (i_host_cmd_data == `CODE_RESET);
  assign cmd_accept   = i_host_cmd_we & (selected | cmd_is_diag);

  // hardware events; only the request and stop events are gated by their own enables
  assign xend_event  = i_xfer_end | (atapi & (i_packet_rcvd | i_mem_xfer_done));
  assign drq_event   = cfg_r[`CFG_DRQ_EN] & cfg_r[`CFG_AUTODRQ] & i_pkt_reload;
  assign ustop_event = cfg_r[`CFG_USTOP_EN] & i_ultra_early_stop
                     & i_ultra_remaining_nz;
  assign pkt_event   = i_pkt_seq_done | i_ultra_xfer_end;

  // set requests per status bit
  assign set_req[`BIT_CMD_IRQ]   = atapi & cmd_accept;
  assign set_req[`BIT_XEND_IRQ]  = xend_event;
  assign set_req[`BIT_DRQ_IRQ]   = drq_event;
  assign set_req[`BIT_USTOP_IRQ] = ustop_event;
  assign set_req[`BIT_XBUSY]     = wr_trig | i_xfer_end;
  assign set_req[`BIT_SRST_IRQ]  = atapi & srst_rise;
  assign set_req[`BIT_RST_CMD]   = cmd_accept;
  assign set_req[`BIT_PKT_DONE]  = pkt_event;

  // value loaded when a set request is present
  assign set_val[`BIT_CMD_IRQ]   = 1'b1;
  assign set_val[`BIT_XEND_IRQ]  = 1'b1;
  assign set_val[`BIT_DRQ_IRQ]   = 1'b1;
  assign set_val[`BIT_USTOP_IRQ] = 1'b1;
  // a trigger in the ending cycle starts the next transfer, so busy stays
  assign set_val[`BIT_XBUSY]     = wr_trig;
  assign set_val[`BIT_SRST_IRQ]  = 1'b1;
  assign set_val[`BIT_RST_CMD]   = cmd_is_reset;
  // ultra end reports integrity and overrides the packet-done mark
  assign set_val[`BIT_PKT_DONE]  = i_ultra_xfer_end ? i_ultra_crc_ok : 1'b1;

  // clear requests per status bit
  assign clr_req[`BIT_CMD_IRQ]   = w1c[`BIT_CMD_IRQ] | rd_cmd;
  assign clr_req[`BIT_XEND_IRQ]  = w1c[`BIT_XEND_IRQ] | wr_ack;
  assign clr_req[`BIT_DRQ_IRQ]   = w1c[`BIT_DRQ_IRQ];
  assign clr_req[`BIT_USTOP_IRQ] = w1c[`BIT_USTOP_IRQ];
  assign clr_req[`BIT_XBUSY]     = 1'b0;
  assign clr_req[`BIT_SRST_IRQ]  = w1c[`BIT_SRST_IRQ] | rd_devctl;
  assign clr_req[`BIT_RST_CMD]   = rd_cmd;
  assign clr_req[`BIT_PKT_DONE]  = wr_ack;

  // set wins over a clear in the same cycle so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_stat
      assign stat_nxt[gi] = set_req[gi] ? set_val[gi] : (stat_r[gi] & ~clr_req[gi]);
    end
  endgenerate

  // read views with their fixed bits
  assign devctl_view = {4'h0, 1'b1, devctl_r[2:1], 1'b0};
  assign feat_view   = {6'h00, feat_r[1:0]};

  always @* begin
    rd_mux = 8'h00;
    case (i_address)
      `OFS_DEVCTL_VIEW: rd_mux = devctl_view;
      `OFS_FEAT_VIEW:   rd_mux = feat_view;
      `OFS_IRQ_STATUS:  rd_mux = stat_r;
      `OFS_DEVCFG:      rd_mux = cfg_r;
      `OFS_CMD_READ:    rd_mux = cmd_r;
      default:          rd_mux = 8'h00;
    endcase
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      devctl_r        <= 8'h00;
      feat_r          <= 8'h00;
      cmd_r           <= 8'h00;
      cfg_r           <= `CFG_RESET;
      stat_r          <= 8'h00;
      ack_r           <= 1'b0;
      o_host_busy_set <= 1'b0;
      o_readdata      <= 8'h00;
    end else begin
      ack_r           <= req & ~ack_r;
      stat_r          <= stat_nxt;
      o_host_busy_set <= srst_rise;
      if (i_host_devctl_we)
        devctl_r <= i_host_devctl_data;
      if (i_host_feat_we)
        feat_r <= i_host_feat_data;
      // unselected drives only latch the diagnostic code
      if (cmd_accept)
        cmd_r <= i_host_cmd_data;
      if (wr_cfg)
        cfg_r <= i_writedata;
      // loaded in the wait cycle so data stand when the wait drops
      if (!ack_r & i_read)
        o_readdata <= rd_mux;
    end
  end
endmodule

// >>> logic/atapi_irq_map.vh
// register offsets, field positions and codes of the interface status block
`ifndef ATAPI_IRQ_MAP_VH
`define ATAPI_IRQ_MAP_VH
`define OFS_DEVCTL_VIEW   16'hff90
`define OFS_FEAT_VIEW     16'hff91
`define OFS_IRQ_STATUS    16'hff92
`define OFS_DEVCFG        16'hff93
`define OFS_CMD_READ      16'hff96
`define OFS_XFER_ACK      16'hff97
`define OFS_XFER_TRIG     16'hff98
`define BIT_CMD_IRQ       7
`define BIT_XEND_IRQ      6
`define BIT_DRQ_IRQ       5
`define BIT_USTOP_IRQ     4
`define BIT_XBUSY         3
`define BIT_SRST_IRQ      2
`define BIT_RST_CMD       1
`define BIT_PKT_DONE      0
`define CFG_ATAPI         0
`define CFG_DEVNUM        1
`define CFG_DRQ_EN        2
`define CFG_USTOP_EN      3
`define CFG_AUTODRQ       4
`define CFG_XEND_MASK     5
`define CODE_DIAG         8'h90
`define CODE_RESET        8'h08
`define CFG_RESET         8'h01
`endif

// >>> test/atapi_irq_monitor.sv
// port checker for the atapi interface status block
`timescale 1ns/1ps
module atapi_irq_monitor (
  input wire        i_clk, i_resetn, i_read, i_write, o_waitrequest, i_xfer_end,
  input wire        i_host_devctl_we, i_host_cmd_we, o_host_irq_oe, o_host_busy_set, o_cpu_irq,
  input wire [15:0] i_address,
  input wire [7:0]  i_writedata, o_readdata, i_host_devctl_data, i_host_cmd_data
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire req = i_read | i_write;
  wire srst = i_host_devctl_we & i_host_devctl_data[2];
  wire clr = i_write & !o_waitrequest & i_address == 16'hff92 & i_writedata == 8'hff;
  a_wait_first: assert property (req && !$past(req) |-> o_waitrequest)
    else $error("no wait state");
  a_read_hold: assert property (!i_read |=> $stable(o_readdata))
    else $error("read data moved");
  a_pin_off: assert property (i_host_devctl_we && i_host_devctl_data[1] |=> !o_host_irq_oe)
    else $error("pin driven");
  a_busy_pulse: assert property (srst |-> ##[1:2] o_host_busy_set)
    else $error("no busy");
  a_srst_irq: assert property (srst |-> ##[1:2] o_cpu_irq)
    else $error("no reset irq");
  a_diag_irq: assert property (i_host_cmd_we && i_host_cmd_data == 8'h90 |=> o_cpu_irq)
    else $error("no diag irq");
  a_xend_irq: assert property (i_xfer_end |=> o_cpu_irq)
    else $error("no end irq");
  a_clr_all: assert property (clr && !i_host_cmd_we && !srst && !i_xfer_end |=> !o_cpu_irq)
    else $error("irq kept");
  cover property (srst);
  cover property (clr);
  cover property (i_read && !o_waitrequest);
endmodule
bind atapi_host_irq_status atapi_irq_monitor mon (.*);

// >>> test/atapi_pc_host.sv
// pc host model writing the task file registers
`timescale 1ns/1ps
module atapi_pc_host (
  input  wire        i_clk, i_busy_set,
  output logic       o_we_ctl = 0, o_we_feat = 0, o_we_cmd = 0,
  output logic [7:0] o_data = 8'h00
);
  logic busy_r = 1'b0;
  always @(posedge i_clk) if (i_busy_set) busy_r <= 1'b1;
  // k: 0 device control, 1 features, 2 command
  task automatic put(input int k, input logic [7:0] d);
    @(posedge i_clk);
    if (k == 2 && busy_r) return;
    o_data <= d;
    {o_we_ctl, o_we_feat, o_we_cmd} <= {k == 0, k == 1, k == 2};
    @(posedge i_clk);
    {o_we_ctl, o_we_feat, o_we_cmd} <= 3'b000;
    // released bus must not look like the last byte
    o_data <= ~d;
    if (k == 0 && !d[2]) busy_r <= 1'b0;
  endtask
endmodule

// >>> test/atapi_host_irq_status_tb_top.sv
// self-checking bench for the atapi interface status block
`timescale 1ns/1ps
module atapi_host_irq_status_tb_top;
  logic        clk = 0, resetn = 0, rd = 0, wr = 0, drv = 0, wt, oe, irq, bset, wc, wf, wm, hout;
  logic [15:0] addr = 0;
  logic [7:0]  wd = 0, rnd = 8'h17, rdata, hd, exq[$];
  logic [6:0]  ev = 0;
  logic [27:0] step[43] = '{28'h1_90_ff_00, 28'h0_9f_00_00, 28'h0_90_00_08,
    28'h2_00_02_00, 28'h0_90_00_0a, 28'h8_00_00_00, 28'h2_00_00_00, 28'h8_00_00_01,
    28'h2_00_04_00, 28'h7_00_00_01, 28'h0_92_00_04, 28'h0_90_00_0c, 28'h0_92_00_00,
    28'h2_00_00_00, 28'h4_00_08_00, 28'h0_92_00_82, 28'h0_96_00_08, 28'h0_92_00_00,
    28'h6_00_01_00, 28'h8_00_00_00, 28'h4_00_a0_00, 28'h4_00_90_00, 28'h1_92_00_00,
    28'h0_92_00_80, 28'h1_92_80_00, 28'h1_98_00_00, 28'h5_00_05_00, 28'h0_92_00_09,
    28'h7_00_00_00, 28'h5_00_00_00, 28'h0_92_00_41, 28'h1_92_ff_00, 28'h0_92_00_01,
    28'h1_97_00_00, 28'h5_00_01_00, 28'h0_92_00_40, 28'h1_97_00_00, 28'h1_93_1d_00,
    28'h5_00_03_00, 28'h5_00_04_00, 28'h0_92_00_30, 28'h5_00_06_00, 28'h0_92_00_31};
  int          n_fail = 0, n_checks = 0;
  atapi_host_irq_status dut (.i_clk(clk), .i_resetn(resetn), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wd), .o_readdata(rdata), .o_waitrequest(wt),
    .i_host_devctl_we(wc), .i_host_devctl_data(hd), .i_host_feat_we(wf), .i_host_feat_data(hd),
    .i_host_cmd_we(wm), .i_host_cmd_data(hd), .i_host_drive_bit(drv), .i_xfer_end(ev[0]),
    .i_packet_rcvd(ev[1]), .i_mem_xfer_done(ev[2]), .i_pkt_reload(ev[3]),
    .i_ultra_early_stop(ev[4]), .i_ultra_remaining_nz(1'b1), .i_pkt_seq_done(ev[5]),
    .i_ultra_xfer_end(ev[6]), .i_ultra_crc_ok(hd[0]), .i_host_irq_req(hd[1]),
    .o_host_irq_out(hout), .o_host_irq_oe(oe), .o_host_busy_set(bset), .o_cpu_irq(irq));
  atapi_pc_host host (.i_clk(clk), .i_busy_set(bset), .o_we_ctl(wc), .o_we_feat(wf),
    .o_we_cmd(wm), .o_data(hd));
  initial forever #20 clk = ~clk;
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {addr, wd, rd, wr} <= {8'hff, a, d, !w, w};
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 16);
    if (n >= 16) begin
      n_fail++;
      tally_and_finish;
    end
    {rd, wr} <= 2'b00;
  endtask
  always @(posedge clk) if (rd && wt === 1'b0) chk(rdata, exq.pop_front());
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) begin
      rnd = lfsr(rnd);
      host.put(1, rnd);
      exq.push_back({6'h0, rnd[1:0]});
      bus(0, 8'h91, 8'h00);
    end
    foreach (step[i]) begin
      case (step[i][27:24])
        0: begin
          exq.push_back(step[i][7:0]);
          bus(0, step[i][23:16], 8'h00);
        end
        1: bus(1, step[i][23:16], step[i][15:8]);
        2, 3, 4: host.put(int'(step[i][27:24]) - 2, step[i][15:8]);
        5: begin
          @(posedge clk);
          ev[step[i][10:8]] <= 1'b1;
          @(posedge clk);
          ev <= '0;
        end
        6: @(posedge clk) drv <= step[i][8];
        7: @(negedge clk) chk({7'h0, irq}, step[i][7:0]);
        default: begin
          @(negedge clk) chk({7'h0, oe}, step[i][7:0]);
          chk({7'h0, hout}, step[i][7:0] & {7'h0, hd[1]});
        end
      endcase
    end
    tally_and_finish;
  end
endmodule
